// file: dda_pkg.sv
package dda_pkg;
    // array geometry and pin widths
    localparam int DQ_W   = 4;
    localparam int BANKS  = 8;
    localparam int BA_W   = 3;
    localparam int ADDR_W = 16;
    localparam int WORDS  = 8;
    localparam int LINE_W = DQ_W * WORDS;
    localparam int IDX_W  = 6;
    localparam int LINES  = 64;
    // address fields sampled with commands
    localparam int AP_BIT  = 10;
    localparam int BC_BIT  = 12;
    localparam int COL_LSB = 3;
    localparam logic [2:0] MR0_BA = 3'h0;
    // burst length field of mode register 0
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [1:0] LAST_B8 = 2'h3;
    localparam logic [1:0] LAST_B4 = 2'h1;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_WR    = 4'h4;
    localparam logic [3:0] CMD_RD    = 4'h5;
    localparam logic [3:0] CMD_DESEL = 4'hF;
    // latencies in link clock cycles
    localparam int CNT_W   = 4;
    localparam int CL_CYC  = 6;
    localparam int CWL_CYC = 5;
    localparam logic [3:0] RD_PRE_AT  = 4'(CL_CYC - 3);
    localparam logic [3:0] WR_OPEN_AT = 4'(CWL_CYC - 1);
    // self-timed precharge, rounded up to whole link cycles
    localparam int T_RP_PS        = 13750;
    localparam int LINK_PERIOD_PS = 30000;
    localparam int RP_RAW = (T_RP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam logic [3:0] RP_CNT = 4'(RP_CYC);
    // transfer and power states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RLAT = 6'h02,
        ST_RPRE = 6'h04,
        ST_RDAT = 6'h08,
        ST_WLAT = 6'h10,
        ST_WDAT = 6'h20
    } dda_xfer_t;
    typedef enum logic [2:0] {
        PW_ACT = 3'h1,
        PW_PD  = 3'h2,
        PW_SR  = 3'h4
    } dda_pwr_t;
endpackage

// file: dda_sync.sv
module dda_sync
    import dda_pkg::*;
#(
    parameter int W = 1
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1_q;

    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            q    <= s1_q;
        end
    end
endmodule

// file: dda_bank.sv
module dda_bank
    import dda_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              act,
    input  wire logic              pre,
    input  wire logic              ap_start,
    input  wire logic [ADDR_W-1:0] row_in,
    output logic                   is_open,
    output logic [ADDR_W-1:0]      row
);
    logic [CNT_W-1:0] ap_cnt_q;

    // open on activate, close on precharge or when the timer runs out
    always_ff @(posedge clk) begin
        if (rst) begin
            is_open  <= 1'b0;
            ap_cnt_q <= '0;
        end else if (pre) begin
            is_open  <= 1'b0;
            ap_cnt_q <= '0;
        end else if (act) begin
            is_open <= 1'b1;
        end else if (ap_start) begin
            ap_cnt_q <= RP_CNT;
        end else if (ap_cnt_q == 4'h1) begin
            is_open  <= 1'b0;
            ap_cnt_q <= '0;
        end else if (ap_cnt_q != '0) begin
            ap_cnt_q <= ap_cnt_q - 4'h1;
        end
    end

    // row latched with the activate
    always_ff @(posedge clk) begin
        if (rst) begin
            row <= '0;
        end else if (act) begin
            row <= row_in;
        end
    end
endmodule

// file: dda_core.sv
// Operation
// - one access is an 8-word line moved over four link cycles.
// - two data words per link cycle, first and second half, both directions.
// - read strobe driven with read data, edges aligned to data.
// - command, control and address pins sampled on every rising link edge.
// - first write word taken on first strobe high after write preamble.
// - first read word follows one preamble cycle of low strobe.
// - burst starts at chosen column and runs in programmed order; the code uses one fixed order and has no order setting.
// - activate uses sampled bank and address to open a row.
// - read or write uses sampled bank and column for burst start.
// - bursts of eight words and chopped bursts of four.
// - auto precharge closes the row a precharge time after the burst.
// - eight banks work independently and overlap.
// - self refresh and power-down modes entered by clock enable low.
// - commands act only while the delay-locked loop is enabled; the code also enters self refresh and power-down with the loop disabled.
// - on-the-fly mode: burst_chop_select high gives eight, low four.
// - address bit ten with read or write asks for auto precharge.
// - commands with chip select high are ignored.
// - words with write_mask high are not stored.
module dda_core
    import dda_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              dll_enable,
    output logic                   self_refresh_active,
    output logic                   power_down_active,
    output logic [BANKS-1:0]       bank_open,
    output logic                   burst_done,
    input  wire logic              mem_clk,
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [2*DQ_W-1:0] dq_in,
    input  wire logic [1:0]        write_mask,
    input  wire logic              dqs_in,
    output logic [2*DQ_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic [1:0]             dqs_out,
    output logic                   dqs_oe
);
    logic                lrst;
    logic                dll_s;
    logic [3:0]          cmd_q;
    logic                cke_q;
    logic [BA_W-1:0]     ba_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [2*DQ_W-1:0]   dq_q;
    logic [1:0]          mask_q;
    logic                dqs_q;
    dda_pwr_t            pwr_q;
    dda_xfer_t           st_q;
    logic [1:0]          mr_bl_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [1:0]          beat_q;
    logic                pre_seen_q;
    logic [IDX_W-1:0]    idx_q;
    logic [2:0]          col_q;
    logic [BA_W-1:0]     bank_q;
    logic                ap_q;
    logic                chop_q;
    logic                acc_tgl_q;
    logic [LINE_W-1:0]   line_q;
    logic [LINE_W-1:0]   mem_q [LINES];
    logic [LINE_W-1:0]   wmerge;
    logic [BANKS-1:0]    open_v;
    logic [ADDR_W-1:0]   row_v [BANKS];
    logic                live;
    logic                act_go;
    logic                pre_go;
    logic                mrs_go;
    logic                rd_go;
    logic                wr_go;
    logic                chop_d;
    logic [IDX_W-1:0]    idx_d;
    logic                last_beat;
    logic                cap;
    logic                rd_done;
    logic                wr_done;
    logic                ap_go;
    logic [1:0]          next_beat;
    logic [BANKS+2:0]    stat_s;
    logic                tgl_d_q;

    // burst order: low two bits wrap, bit two flips for the second half
    function automatic logic [2:0] ord(input logic [2:0] st, input logic [2:0] k);
        ord = {st[2] ^ k[2], 2'(st[1:0] + k[1:0])};
    endfunction

    // two words of one beat from a line
    function automatic logic [2*DQ_W-1:0] get_pair(input logic [LINE_W-1:0] ln,
                                                   input logic [2:0] st, input logic [1:0] b);
        logic [2:0] p0;
        logic [2:0] p1;
        p0 = ord(st, {b, 1'b0});
        p1 = ord(st, {b, 1'b1});
        get_pair = {ln[p1*DQ_W +: DQ_W], ln[p0*DQ_W +: DQ_W]};
    endfunction

    // merge one beat into a line, skipping masked words
    function automatic logic [LINE_W-1:0] put_pair(input logic [LINE_W-1:0] ln,
                                                   input logic [2:0] st, input logic [1:0] b,
                                                   input logic [2*DQ_W-1:0] d, input logic [1:0] m);
        logic [2:0] p;
        put_pair = ln;
        for (int h = 0; h < 2; h++) begin
            p = ord(st, {b, 1'(h)});
            if (!m[h]) begin
                put_pair[p*DQ_W +: DQ_W] = d[h*DQ_W +: DQ_W];
            end
        end
    endfunction

    // reset and loop enable carried into the link domain
    dda_sync #(.W(2)) u_link_sync (
        .clk (mem_clk),
        .rst (1'b0),
        .d   ({rst, dll_enable}),
        .q   ({lrst, dll_s})
    );

    // pins registered on each rising link edge
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            cmd_q  <= CMD_DESEL;
            cke_q  <= 1'b1;
            ba_q   <= '0;
            addr_q <= '0;
            dq_q   <= '0;
            mask_q <= '0;
            dqs_q  <= 1'b0;
        end else begin
            cmd_q  <= {cs_n, ras_n, cas_n, we_n};
            cke_q  <= cke;
            ba_q   <= ba;
            addr_q <= addr;
            dq_q   <= dq_in;
            mask_q <= write_mask;
            dqs_q  <= dqs_in;
        end
    end

    // command decode
    assign live   = dll_s && cke_q && (pwr_q == PW_ACT) && !cmd_q[3];
    assign act_go = live && (cmd_q == CMD_ACT);
    assign pre_go = live && (cmd_q == CMD_PRE);
    assign mrs_go = live && (cmd_q == CMD_MRS) && (ba_q == MR0_BA);
    assign rd_go  = live && (cmd_q == CMD_RD) && (st_q == ST_IDLE) && open_v[ba_q];
    assign wr_go  = live && (cmd_q == CMD_WR) && (st_q == ST_IDLE) && open_v[ba_q];
    assign chop_d = (mr_bl_q == BL_FIX4) || ((mr_bl_q == BL_OTF) && !addr_q[BC_BIT]);
    assign idx_d  = {ba_q, row_v[ba_q][0], addr_q[COL_LSB +: 2]};

    // power modes follow clock enable
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            pwr_q <= PW_ACT;
        end else begin
            case (pwr_q)
                PW_ACT: begin
                    if (!cke_q && st_q == ST_IDLE) begin
                        pwr_q <= (cmd_q == CMD_REF) ? PW_SR : PW_PD;
                    end
                end
                PW_PD, PW_SR: begin
                    if (cke_q) begin
                        pwr_q <= PW_ACT;
                    end
                end
                default: pwr_q <= PW_ACT;
            endcase
        end
    end

    // burst length setting from mode register 0
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            mr_bl_q <= BL_FIX8;
        end else if (mrs_go) begin
            mr_bl_q <= addr_q[1:0];
        end
    end

    // access details held for the length of the burst
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            idx_q  <= '0;
            col_q  <= '0;
            bank_q <= '0;
            ap_q   <= 1'b0;
            chop_q <= 1'b0;
        end else if (rd_go || wr_go) begin
            idx_q  <= idx_d;
            col_q  <= addr_q[2:0];
            bank_q <= ba_q;
            ap_q   <= addr_q[AP_BIT];
            chop_q <= chop_d;
        end
    end

    assign last_beat = (beat_q == (chop_q ? LAST_B4 : LAST_B8));
    assign cap       = ((st_q == ST_WLAT) && pre_seen_q && dqs_q) || ((st_q == ST_WDAT) && dqs_q);
    assign rd_done   = (st_q == ST_RDAT) && last_beat;
    assign wr_done   = (st_q == ST_WDAT) && dqs_q && last_beat;
    assign ap_go     = (rd_done || wr_done) && ap_q;
    assign next_beat = (st_q == ST_RPRE) ? 2'h0 : 2'(beat_q + 2'h1);

    // transfer sequencing, one burst at a time
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            beat_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q  <= '0;
                    beat_q <= '0;
                    if (rd_go) begin
                        st_q <= ST_RLAT;
                    end else if (wr_go) begin
                        st_q <= ST_WLAT;
                    end
                end
                ST_RLAT: begin
                    if (cnt_q == RD_PRE_AT) begin
                        st_q <= ST_RPRE;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_RPRE: begin
                    st_q   <= ST_RDAT;
                    beat_q <= '0;
                end
                ST_RDAT: begin
                    if (last_beat) begin
                        st_q <= ST_IDLE;
                    end else begin
                        beat_q <= beat_q + 2'h1;
                    end
                end
                ST_WLAT: begin
                    if (cnt_q != WR_OPEN_AT) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (cap) begin
                        st_q   <= ST_WDAT;
                        beat_q <= 2'h1;
                    end
                end
                ST_WDAT: begin
                    if (cap && last_beat) begin
                        st_q <= ST_IDLE;
                    end else if (cap) begin
                        beat_q <= beat_q + 2'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // write preamble: strobe low once the write window opens
    always_ff @(posedge mem_clk) begin
        if (lrst || wr_go) begin
            pre_seen_q <= 1'b0;
        end else if (st_q == ST_WLAT && cnt_q == WR_OPEN_AT && !dqs_q) begin
            pre_seen_q <= 1'b1;
        end
    end

    // line buffer: loaded at the column command, merged on each write beat
    assign wmerge = put_pair(line_q, col_q, beat_q, dq_q, mask_q);
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            line_q <= '0;
        end else if (rd_go || wr_go) begin
            line_q <= mem_q[idx_d];
        end else if (cap) begin
            line_q <= wmerge;
        end
    end

    // whole line written back once the last beat is in
    always_ff @(posedge mem_clk) begin
        if (wr_done) begin
            mem_q[idx_q] <= wmerge;
        end
    end

    // read data register, one beat ahead of the strobe
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            dq_out <= '0;
        end else if (st_q == ST_RPRE || (st_q == ST_RDAT && !last_beat)) begin
            dq_out <= get_pair(line_q, col_q, next_beat);
        end
    end

    // strobe low in preamble, high then low in each data beat
    assign dq_oe   = (st_q == ST_RDAT);
    assign dqs_oe  = (st_q == ST_RPRE) || (st_q == ST_RDAT);
    assign dqs_out = (st_q == ST_RDAT) ? 2'b01 : 2'b00;

    // eight independent banks
    for (genvar gi = 0; gi < BANKS; gi++) begin : g_bank
        dda_bank u_bank (
            .clk      (mem_clk),
            .rst      (lrst),
            .act      (act_go && ba_q == BA_W'(gi)),
            .pre      (pre_go && (addr_q[AP_BIT] || ba_q == BA_W'(gi))),
            .ap_start (ap_go && bank_q == BA_W'(gi)),
            .row_in   (addr_q),
            .is_open  (open_v[gi]),
            .row      (row_v[gi])
        );
    end

    // burst completion toggle for the core side
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            acc_tgl_q <= 1'b0;
        end else if (rd_done || wr_done) begin
            acc_tgl_q <= !acc_tgl_q;
        end
    end

    // status brought over to the core clock
    dda_sync #(.W(BANKS + 3)) u_core_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({open_v, pwr_q == PW_SR, pwr_q == PW_PD, acc_tgl_q}),
        .q   (stat_s)
    );

    // core-side status registers and completion pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bank_open           <= '0;
            self_refresh_active <= 1'b0;
            power_down_active   <= 1'b0;
            tgl_d_q             <= 1'b0;
            burst_done          <= 1'b0;
        end else begin
            bank_open           <= stat_s[BANKS+2:3];
            self_refresh_active <= stat_s[2];
            power_down_active   <= stat_s[1];
            tgl_d_q             <= stat_s[0];
            burst_done          <= stat_s[0] ^ tgl_d_q;
        end
    end

    // checks on the link side
    localparam int A_RL = CL_CYC;
    localparam int A_AP = RP_CYC + 1;
    default clocking cb @(posedge mem_clk); endclocking
    default disable iff (lrst);

    AST_BL8_LEN: assert property (rd_go && !chop_d |-> ##A_RL dq_oe [*4] ##1 !dq_oe)
        else $error("eight-word read burst has wrong timing or length");
    AST_BC4_LEN: assert property (rd_go && chop_d |-> ##A_RL dq_oe [*2] ##1 !dq_oe)
        else $error("chopped read burst has wrong timing or length");
    AST_RD_PREAMBLE: assert property ($rose(dq_oe) |-> $past(dqs_oe) && $past(dqs_out) == 2'b00)
        else $error("read data not preceded by strobe preamble");
    AST_RD_STROBE: assert property (dq_oe |-> dqs_oe && dqs_out == 2'b01 && $past(dqs_oe))
        else $error("read strobe not aligned with read data");
    AST_DLL_GATE: assert property (!dll_s && st_q == ST_IDLE |=> st_q == ST_IDLE)
        else $error("access started with the loop disabled");
    AST_CS_IGNORE: assert property (cmd_q[3] && st_q == ST_IDLE |=> st_q == ST_IDLE)
        else $error("command taken while deselected");
    AST_ACT_OPENS: assert property (act_go |=> open_v[$past(ba_q)] && row_v[$past(ba_q)] == $past(addr_q))
        else $error("activate did not open the addressed row");
    AST_AP_CLOSE: assert property (ap_go |-> ##A_AP !open_v[$past(bank_q, A_AP)])
        else $error("auto precharge did not close the bank in time");
    AST_SR_HOLD: assert property (pwr_q == PW_SR && !cke_q |=> pwr_q == PW_SR)
        else $error("self refresh left while clock enable low");

    COV_READ8: cover property (rd_go && !chop_d ##A_RL dq_oe [*4]);
    COV_WRITE: cover property (wr_done);
    COV_AUTOPRE: cover property (ap_go ##A_AP !open_v[bank_q]);
endmodule

// file: dda_ctl_model.sv
module dda_ctl_model
    import dda_pkg::*;
(
    input  wire logic         mem_clk,
    output logic              cke,
    output logic              cs_n,
    output logic              ras_n,
    output logic              cas_n,
    output logic              we_n,
    output logic [BA_W-1:0]   ba,
    output logic [ADDR_W-1:0] addr,
    output logic [7:0]        dq_in,
    output logic [1:0]        write_mask,
    output logic              dqs_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pins from time zero
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = CMD_DESEL;
        ba = 3'h0;
        addr = 16'h0000;
        dq_in = 8'h00;
        write_mask = 2'h0;
        dqs_in = 1'b0;
    end
    // one command for one link cycle, then deselect and scramble the address
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
        @(negedge mem_clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge mem_clk);
        {cs_n, ras_n, cas_n, we_n} = CMD_DESEL;
        addr = ~a;
    endtask
    // clock enable change, optionally with a command
    task automatic clk_en(input logic en, input logic [3:0] c);
        @(negedge mem_clk);
        cke = en;
        {cs_n, ras_n, cas_n, we_n} = c;
        @(negedge mem_clk);
        {cs_n, ras_n, cas_n, we_n} = CMD_DESEL;
    endtask
    // refresh series: refreshes start four link cycles apart when the part runs hot, six otherwise
    task automatic refresh(input logic hot, input int n);
        for (int i = 0; i < n; i++) begin
            cmd(CMD_REF, 3'h0, 16'h0000);
            repeat (hot ? 2 : 4) @(negedge mem_clk);
        end
    endtask
    // write burst: strobe low as preamble, then strobed beats
    task automatic wr(input logic [2:0] b, input logic [15:0] a, input logic [31:0] d,
                      input logic [7:0] m, input int beats);
        cmd(CMD_WR, b, a);
        // strobe stays low through pin cycle CWL_CYC as the preamble
        repeat (CWL_CYC - 1) @(negedge mem_clk);
        for (int i = 0; i < beats; i++) begin
            @(negedge mem_clk);
            dqs_in = 1'b1;
            dq_in = d[8*i +: 8];
            write_mask = m[2*i +: 2];
        end
        @(negedge mem_clk);
        dqs_in = 1'b0;
        dq_in = ~dq_in;
        repeat (2) @(negedge mem_clk);
    endtask
endmodule

// file: ddr3_sdram_access_core_bench.sv
module ddr3_sdram_access_core_bench
    import dda_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        mem_clk, rst, dll_enable, sr_act, pd_act, burst_done, dq_oe, dqs_oe;
    logic        cke, cs_n, ras_n, cas_n, we_n, dqs_in;
    logic [7:0]  bank_open, dq_in, dq_out;
    logic [2:0]  ba, b;
    logic [15:0] addr, a;
    logic [1:0]  write_mask, dqs_out;
    logic [31:0] exp_mem [LINES];
    logic [15:0] rows [BANKS];
    int          n_mismatch, tests_run, n_done, n_burst, oe_cnt, o;

    dda_core dut (.ref_clk(ref_clk), .rst(rst), .dll_enable(dll_enable), .self_refresh_active(sr_act),
        .power_down_active(pd_act), .bank_open(bank_open), .burst_done(burst_done), .mem_clk(mem_clk),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .dq_in(dq_in), .write_mask(write_mask), .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .dqs_out(dqs_out), .dqs_oe(dqs_oe));
    dda_ctl_model ctl (.mem_clk(mem_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .write_mask(write_mask), .dqs_in(dqs_in));

    // core clock, and a link clock offset in phase
    always #4 ref_clk = ~ref_clk;
    initial begin
        mem_clk = 1'b0;
        #1.3;
        forever #15 mem_clk = ~mem_clk;
    end
    // count completion pulses and driven data cycles
    always @(posedge ref_clk) if (burst_done === 1'b1) n_done++;
    always @(posedge mem_clk) if (dq_oe === 1'b1) oe_cnt++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (16) @(negedge ref_clk);
    endtask
    // column of burst word k for a start column
    function automatic logic [2:0] wcol(input logic [2:0] c, input int k);
        return {c[2] ^ k[2], c[1:0] + k[1:0]};
    endfunction
    function automatic logic [5:0] line_of(input logic [2:0] bk, input logic [15:0] ad);
        return {bk, rows[bk][0], ad[4:3]};
    endfunction
    // write a burst and update the expected array
    task automatic do_wr(input logic [2:0] bk, input logic [15:0] ad, input logic [31:0] d,
                         input logic [7:0] m, input int beats);
        logic [5:0] ln;
        ln = line_of(bk, ad);
        n_burst++;
        ctl.wr(bk, ad, d, m, beats);
        for (int k = 0; k < 2*beats; k++)
            if (!m[k]) exp_mem[ln][4*wcol(ad[2:0], k) +: 4] = d[4*k +: 4];
    endtask
    // read a burst and compare every beat
    task automatic do_rd(input logic [2:0] bk, input logic [15:0] ad, input int beats);
        logic [5:0] ln;
        logic [7:0] e;
        logic [2:0] pre;
        int         n;
        ln = line_of(bk, ad);
        n = 0;
        pre = 3'h0;
        n_burst++;
        ctl.cmd(CMD_RD, bk, ad);
        while (dq_oe !== 1'b1 && n < 12) begin
            pre = {dqs_oe, dqs_out};
            @(negedge mem_clk);
            n++;
        end
        check(pre, 3'h4);
        for (int i = 0; i < beats; i++) begin
            for (int j = 0; j < 2; j++) e[4*j +: 4] = exp_mem[ln][4*wcol(ad[2:0], 2*i+j) +: 4];
            check(dq_out, e);
            check({dq_oe, dqs_oe, dqs_out}, 4'hD);
            @(negedge mem_clk);
        end
        check(dq_oe, 1'b0);
        repeat (2) @(negedge mem_clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        #200_000;
        n_mismatch++;
        complete_run();
    end
    // main sequence
    initial begin
        void'($urandom(32'h0000_704b));
        rst = 1'b1;
        dll_enable = 1'b1;
        repeat (4) @(negedge mem_clk);
        @(negedge ref_clk) rst = 1'b0;
        repeat (4) @(negedge mem_clk);
        check({bank_open, sr_act, pd_act, dq_oe, dqs_oe}, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < BANKS; i++) begin
            rows[i] = 16'($urandom);
            ctl.cmd(CMD_ACT, 3'(i), rows[i]);
        end
        settle();
        check(bank_open, 8'hFF);
        for (int t = 0; t < 6; t++) begin
            b = 3'($urandom);
            a = 16'($urandom) & 16'hEBFF;
            do_wr(b, a, $urandom, 8'h00, 4);
            do_wr(b, a ^ 16'h0005, $urandom, 8'($urandom), 4);
            do_rd(b, a ^ 16'h0002, 4);
        end
        $display("test random bursts done");
        for (int i = 0; i < 4; i++) begin
            ctl.cmd(CMD_MRS, MR0_BA, {14'h0000, (i < 2) ? BL_OTF : (i == 2) ? BL_FIX4 : BL_FIX8});
            b = 3'($urandom);
            a = {3'h0, 1'(i[0] ^ i[1]), 2'h0, 10'($urandom)};
            do_wr(b, a, $urandom, 8'h00, i[0] ? 4 : 2);
            do_rd(b, a, i[0] ? 4 : 2);
        end
        $display("test burst modes done");
        do_rd(3'h5, 16'h0400, 4);
        settle();
        check(bank_open, 8'hDF);
        ctl.cmd(CMD_PRE, 3'h3, 16'h0000);
        settle();
        check(bank_open, 8'hD7);
        $display("test auto precharge done");
        o = oe_cnt;
        ctl.cmd(CMD_RD | 4'h8, 3'h0, 16'h0000);
        ctl.cmd(CMD_ACT | 4'h8, 3'h5, 16'h0000);
        ctl.cmd(CMD_RD, 3'h5, 16'h0000);
        @(negedge ref_clk) dll_enable = 1'b0;
        settle();
        ctl.cmd(CMD_RD, 3'h0, 16'h0000);
        ctl.cmd(CMD_ACT, 3'h5, 16'h0000);
        repeat (12) @(negedge mem_clk);
        check(oe_cnt, o);
        settle();
        check(bank_open, 8'hD7);
        @(negedge ref_clk) dll_enable = 1'b1;
        settle();
        $display("test ignored commands done");
        ctl.refresh(1'b1, 2);
        settle();
        check(bank_open, 8'hD7);
        ctl.clk_en(1'b0, CMD_DESEL);
        settle();
        check({sr_act, pd_act}, 2'h1);
        ctl.clk_en(1'b1, CMD_DESEL);
        settle();
        ctl.clk_en(1'b0, CMD_REF);
        settle();
        check({sr_act, pd_act}, 2'h2);
        ctl.clk_en(1'b1, CMD_DESEL);
        settle();
        check({sr_act, pd_act}, 2'h0);
        ctl.cmd(CMD_PRE, 3'h0, 16'h0400);
        settle();
        check(bank_open, 8'h00);
        check(n_done, n_burst);
        $display("test power modes done");
        complete_run();
    end
endmodule
